// File: hw/asrc_ctrl.sv
/*
  Controller driving an asynchronous static memory through its pins.
  Assumes the memory pins are external; read data passes a 2-flop sync.
*/
`timescale 1ns/10ps
`include "asrc_params.svh"

// Overview of operation
// - Write enable high during reads
// - Address valid before select goes active
// - Write enable high while address changes
// - Data timed against write end edge
// - Selects active 70 ns before write end
// - Address valid 70 ns before write end
// - Byte enable low 70 ns before end
// - Data stable 30 ns before write end
// - No data drive while device drives
module asrc_ctrl #(
  parameter int ADDR_W = `ASRC_ADDR_W,
  parameter int DATA_W = `ASRC_DATA_W
) (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [ADDR_W-1:0] req_addr_in,
  input wire logic [DATA_W-1:0] req_wdata_in,
  input wire logic [1:0] req_byte_en_in,
  output logic req_ready_out,
  output logic rsp_valid_out,
  output logic [DATA_W-1:0] rsp_rdata_out,
  output logic [ADDR_W-1:0] mem_addr_out,
  output logic select_active_low_out,
  output logic select_active_high_out,
  output logic mem_oe_n_out,
  output logic mem_we_n_out,
  output logic lower_byte_enable_n_out,
  output logic upper_byte_enable_n_out,
  input wire logic [DATA_W-1:0] mem_dq_in,
  output logic [DATA_W-1:0] mem_dq_out,
  output logic mem_dq_oe_out
);
  import asrc_pkg::*;

  localparam logic [`ASRC_CNT_W-1:0] CYC_ACCESS =
    `ASRC_CNT_W'(`ASRC_CYC_MIN(`ASRC_T_ACCESS_NS) + `ASRC_SYNC_STAGES);
  localparam logic [`ASRC_CNT_W-1:0] CYC_WRITE =
    `ASRC_CNT_W'(`ASRC_CYC_MIN(`ASRC_T_WRITE_NS));
  localparam logic [`ASRC_CNT_W-1:0] CYC_GAP =
    `ASRC_CNT_W'(`ASRC_CYC_MIN(`ASRC_T_RELEASE_NS));

  localparam int LANES = `ASRC_LANES;

  // Widths and counts the logic can serve
  if (ADDR_W < 1 || DATA_W != `ASRC_DATA_W) begin : g_bad_width
    $error("asrc_ctrl: unsupported width");
  end
  if (`ASRC_CYC_MIN(`ASRC_T_ACCESS_NS) + `ASRC_SYNC_STAGES >= (1 << `ASRC_CNT_W))
  begin : g_bad_count
    $error("asrc_ctrl: counter too narrow");
  end

  asrc_state_t state;
  logic [`ASRC_CNT_W-1:0] cnt;
  logic is_write;
  logic [DATA_W-1:0] dq_sync1;
  logic [DATA_W-1:0] dq_sync2;
  logic [LANES-1:0] lane_n;
  logic next_we_n;

  assign req_ready_out = (state == ASRC_IDLE);

  // Read data synchroniser
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dq_sync1 <= '0;
      dq_sync2 <= '0;
    end else begin
      dq_sync1 <= mem_dq_in;
      dq_sync2 <= dq_sync1;
    end
  end

  // Sequencer
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= ASRC_IDLE;
      cnt <= `ASRC_CNT_ZERO;
      is_write <= 1'b0;
    end else begin
      case (state)
        ASRC_IDLE: begin
          if (req_valid_in) begin
            is_write <= req_write_in;
            state <= ASRC_SETUP;
          end
        end
        ASRC_SETUP: begin
          cnt <= is_write ? CYC_WRITE : CYC_ACCESS;
          state <= ASRC_STROBE;
        end
        ASRC_STROBE: begin
          if (cnt == `ASRC_CNT_ONE) begin
            state <= ASRC_HOLD;
          end else begin
            cnt <= cnt - `ASRC_CNT_ONE;
          end
        end
        ASRC_HOLD: begin
          cnt <= CYC_GAP;
          state <= ASRC_GAP;
        end
        ASRC_GAP: begin
          if (cnt == `ASRC_CNT_ONE) begin
            state <= ASRC_IDLE;
          end else begin
            cnt <= cnt - `ASRC_CNT_ONE;
          end
        end
        default: state <= ASRC_IDLE;
      endcase
    end
  end

  // Address and data latched per request
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mem_addr_out <= '0;
      mem_dq_out <= '0;
    end else if (state == ASRC_IDLE && req_valid_in) begin
      // Address moves only while write enable high
      mem_addr_out <= req_addr_in;
      mem_dq_out <= req_wdata_in;
    end
  end

  // Byte lane enables, one flop per lane
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
        lane_n[g] <= 1'b1;
      end else if (state == ASRC_IDLE && req_valid_in) begin
        lane_n[g] <= ~req_byte_en_in[g];
      end else if (state == ASRC_GAP) begin
        lane_n[g] <= 1'b1;
      end
    end
  end

  assign lower_byte_enable_n_out = lane_n[0];
  assign upper_byte_enable_n_out = lane_n[1];

  // Write ended by write enable rising
  always_comb begin
    next_we_n = 1'b1;
    if (is_write && state == ASRC_SETUP) begin
      next_we_n = 1'b0;
    end
    if (is_write && state == ASRC_STROBE && cnt != `ASRC_CNT_ONE) begin
      next_we_n = 1'b0;
    end
  end

  // Strobes
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      select_active_low_out <= 1'b1;
      select_active_high_out <= 1'b0;
      mem_we_n_out <= 1'b1;
      mem_oe_n_out <= 1'b1;
      mem_dq_oe_out <= 1'b0;
    end else begin
      select_active_low_out <= ~(state == ASRC_SETUP || state == ASRC_STROBE);
      select_active_high_out <= (state == ASRC_SETUP || state == ASRC_STROBE);
      mem_we_n_out <= next_we_n;
      mem_oe_n_out <= ~(!is_write && (state == ASRC_SETUP || state == ASRC_STROBE));
      mem_dq_oe_out <= is_write && (state == ASRC_SETUP || state == ASRC_STROBE
        || state == ASRC_HOLD);
    end
  end

  // Read capture
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rsp_valid_out <= 1'b0;
      rsp_rdata_out <= '0;
    end else begin
      rsp_valid_out <= 1'b0;
      // Sample after access time plus sync
      if (!is_write && state == ASRC_STROBE && cnt == `ASRC_CNT_ONE) begin
        rsp_valid_out <= 1'b1;
        rsp_rdata_out <= dq_sync2;
      end
    end
  end
endmodule : asrc_ctrl

// File: hw/asrc_params.svh
/*
  Timing and width constants for the asynchronous memory controller.
  Assumes a 250 MHz core clock.
*/
`ifndef ASRC_PARAMS_SVH
`define ASRC_PARAMS_SVH
`define ASRC_CLK_PERIOD_PS 4000
`define ASRC_T_CYCLE_NS 70
`define ASRC_T_ACCESS_NS 70
`define ASRC_T_OE_ACCESS_NS 35
`define ASRC_T_WRITE_NS 70
`define ASRC_T_DATA_SETUP_NS 30
`define ASRC_T_DATA_HOLD_NS 0
`define ASRC_T_RELEASE_NS 35
`define ASRC_SYNC_STAGES 2
`define ASRC_LANES 2
`define ASRC_CYC_MIN(ns) (((ns) * 1000 + `ASRC_CLK_PERIOD_PS - 1) / `ASRC_CLK_PERIOD_PS)
`define ASRC_ADDR_W 19
`define ASRC_DATA_W 16
`define ASRC_CNT_W 6
`define ASRC_CNT_ZERO 6'h00
`define ASRC_CNT_ONE 6'h01
`endif

// File: hw/asrc_pkg.sv
/*
  Types for the asynchronous memory controller.
  Assumes the params header alongside.
*/
package asrc_pkg;
  typedef enum logic [2:0] {
    ASRC_IDLE = 3'h0,
    ASRC_SETUP = 3'h1,
    ASRC_STROBE = 3'h3,
    ASRC_HOLD = 3'h2,
    ASRC_GAP = 3'h6
  } asrc_state_t;
endpackage : asrc_pkg

// File: dv/asrc_chk.sv
/*
  Pin protocol checker for the memory controller.
  Assumes it is bound onto asrc_ctrl.
*/
`timescale 1ns/10ps
module asrc_chk #(
  parameter int ADDR_W = 19
) (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic rsp_valid_out,
  input wire logic [ADDR_W-1:0] mem_addr_out,
  input wire logic select_active_low_out,
  input wire logic select_active_high_out,
  input wire logic mem_oe_n_out,
  input wire logic mem_we_n_out,
  input wire logic lower_byte_enable_n_out,
  input wire logic [15:0] mem_dq_out,
  input wire logic mem_dq_oe_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  wire sel = !select_active_low_out && select_active_high_out;
  a_we_in_read: assert property (!mem_oe_n_out |-> mem_we_n_out)
    else $error("we low in read");
  a_addr_at_sel: assert property ($rose(sel) |-> $stable(mem_addr_out))
    else $error("addr moves at select");
  a_read_sample: assert property ($fell(mem_oe_n_out) |-> ##20 rsp_valid_out)
    else $error("read sampled early");
  a_addr_we_low: assert property (!mem_we_n_out |-> $stable(mem_addr_out))
    else $error("addr moves in write");
  a_sel_wr_end: assert property ($rose(mem_we_n_out) |-> sel && $past(sel, 18))
    else $error("select too short");
  a_addr_wr_end: assert property ($rose(mem_we_n_out) |-> $past(mem_addr_out, 18) == mem_addr_out)
    else $error("addr too short");
  a_lane_wr_end: assert property ($rose(mem_we_n_out) |->
    $past(lower_byte_enable_n_out, 18) == lower_byte_enable_n_out)
    else $error("lane too short");
  a_data_setup: assert property ($rose(mem_we_n_out) |-> mem_dq_oe_out && $past(mem_dq_oe_out, 8)
    && $past(mem_dq_out, 8) == mem_dq_out)
    else $error("data setup short");
  a_no_contend: assert property (!mem_oe_n_out |-> !mem_dq_oe_out)
    else $error("drive during read");
  a_recovery: assert property ($fell(sel) |=> !sel [*8])
    else $error("cycles too close");
  c_read: cover property (rsp_valid_out);
  c_write: cover property ($rose(mem_we_n_out));
  c_lane: cover property ($rose(sel) && lower_byte_enable_n_out);
endmodule : asrc_chk
bind asrc_ctrl asrc_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

// File: dv/asrc_mem_model.sv
/*
  Behavioural static memory on the controller pins.
  Assumes it is the only party besides the controller on the data lines.
*/
`timescale 1ns/10ps
module asrc_mem_model #(
  parameter int ACC_NS = 70
) (
  input wire logic [18:0] a_in,
  input wire logic sel_n_in,
  input wire logic sel_in,
  input wire logic oe_n_in,
  input wire logic we_n_in,
  input wire logic lb_n_in,
  input wire logic ub_n_in,
  input wire logic [15:0] d_in,
  input wire logic d_oe_in,
  output logic [15:0] q_out
);
  logic [15:0] mem [16];
  wire [15:0] w = mem[a_in[3:0]];
  wire on = !sel_n_in && sel_in;
  wire wr = on && !we_n_in;
  wire #(ACC_NS) late = on && !oe_n_in && we_n_in;
  wire rd = late && on && !oe_n_in && we_n_in;
  always @(negedge wr) begin
    if (!lb_n_in) mem[a_in[3:0]][7:0] = d_in[7:0];
    if (!ub_n_in) mem[a_in[3:0]][15:8] = d_in[15:8];
  end
  assign q_out[7:0] = d_oe_in ? d_in[7:0] : (rd && !lb_n_in) ? w[7:0] : ~w[7:0];
  assign q_out[15:8] = d_oe_in ? d_in[15:8] : (rd && !ub_n_in) ? w[15:8] : ~w[15:8];
endmodule : asrc_mem_model

// File: dv/testbench.sv
/*
  Self-checking bench for the memory controller.
  Assumes the memory model as far side.
*/
`timescale 1ns/10ps
module testbench;
  logic core_clk_in, nrst_in, req_valid_in, req_write_in, req_ready_out, rsp_valid_out;
  logic select_active_low_out, select_active_high_out, mem_oe_n_out, mem_we_n_out;
  logic lower_byte_enable_n_out, upper_byte_enable_n_out, mem_dq_oe_out;
  logic [18:0] req_addr_in, mem_addr_out;
  logic [15:0] req_wdata_in, rsp_rdata_out, mem_dq_in, mem_dq_out;
  logic [1:0] req_byte_en_in;
  int errors = 0, samples_checked = 0, pulses = 0;
  asrc_ctrl u_dut (.*);
  asrc_mem_model u_mem (.a_in(mem_addr_out), .sel_n_in(select_active_low_out),
    .sel_in(select_active_high_out), .oe_n_in(mem_oe_n_out), .we_n_in(mem_we_n_out),
    .lb_n_in(lower_byte_enable_n_out), .ub_n_in(upper_byte_enable_n_out),
    .d_in(mem_dq_out), .d_oe_in(mem_dq_oe_out), .q_out(mem_dq_in));
  always @(posedge core_clk_in) if (rsp_valid_out === 1'b1) pulses++;
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [18:0] a, input logic [15:0] d,
    input logic [1:0] be);
    int n;
    @(negedge core_clk_in);
    req_valid_in = 1'b1;
    req_write_in = w;
    req_addr_in = a;
    req_wdata_in = d;
    req_byte_en_in = be;
    @(negedge core_clk_in);
    req_valid_in = 1'b0;
    n = 0;
    while (req_ready_out !== 1'b1 && n++ < 60) @(negedge core_clk_in);
    if (req_ready_out !== 1'b1) begin
      errors++;
      $display("[ERR] ready expected 1 seen %b", req_ready_out);
    end
  endtask : xfer
  task automatic rd(input logic [18:0] a, input logic [15:0] exp);
    int p;
    p = pulses;
    xfer(1'b0, a, 16'h0000, 2'h3);
    chk("pulses", 16'(p + 1), 16'(pulses));
    chk("rdata", exp, rsp_rdata_out);
  endtask : rd
  task automatic t_word;
    xfer(1'b1, 19'h00003, 16'hA5C3, 2'h3);
    rd(19'h00003, 16'hA5C3);
    $display("t_word done");
  endtask : t_word
  task automatic t_lanes;
    xfer(1'b1, 19'h00003, 16'h0011, 2'h1);
    rd(19'h00003, 16'hA511);
    xfer(1'b1, 19'h00003, 16'h2200, 2'h2);
    rd(19'h00003, 16'h2211);
    $display("t_lanes done");
  endtask : t_lanes
  task automatic t_back;
    xfer(1'b1, 19'h00005, 16'h1234, 2'h3);
    xfer(1'b1, 19'h00006, 16'hFEDC, 2'h3);
    rd(19'h00006, 16'hFEDC);
    rd(19'h00005, 16'h1234);
    $display("t_back done");
  endtask : t_back
  task automatic conclude;
    $display("errors %0d checks %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  initial begin
    core_clk_in = 1'b0;
    forever #2 core_clk_in = ~core_clk_in;
  end
  initial begin
    #20000;
    errors++;
    conclude();
  end
  initial begin
    nrst_in = 1'b0;
    req_valid_in = 1'b0;
    req_write_in = 1'b0;
    req_addr_in = 19'h00000;
    req_wdata_in = 16'h0000;
    req_byte_en_in = 2'h0;
    repeat (10) @(negedge core_clk_in);
    nrst_in = 1'b1;
    t_word();
    t_lanes();
    t_back();
    conclude();
  end
endmodule : testbench
